// [hdl/lldz_core.sv]
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
// How it works
// - Slew done needs rise then fall in dead time
// - No slew done means wait for dead time ceiling
// - Measure high-to-low dead time, reuse it low-to-high
// - Wrong current polarity at turn-off sets capacitive flag
// - Flag holds until next gate turn-off re-evaluation or fault exit
// - Capacitive: turn on at flip, slew done, ceiling
// - Capacitive dead time ceiling is 150 microseconds
// - Capacitive event pulls soft start, steps frequency up then ramps it down
// - Light load disables capacitive detection
// - Four consecutive peak trips cause fault
// - High average current for 2 ms causes fault
// - Low average current for 50 ms causes fault
// - Winding overvoltage five cycles causes fault
// - Bulk below stop level faults immediately
// - Bulk overvoltage faults; restart only once cleared
// - Bootstrap undervoltage kills high gate, no fault
// - Gate supply undervoltage kills both gates, faults
// - Polarity edges blanked first 400 ns of dead time
// - Peak comparator latched through positive half cycle, counted once a cycle
// - Startup ignores peak comparator first 15 cycles
module lldz_core #(
    parameter int CAP_MAX_CYC = lldz_pkg::CAP_MAX_DT_CYC,
    parameter int AVG_HI_LIMIT = lldz_pkg::AVG_HI_CYC,
    parameter int AVG_LO_LIMIT = lldz_pkg::AVG_LO_CYC,
    parameter int WAIT_CYC = lldz_pkg::FAULT_WAIT_CYC
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // Analog comparators
    input wire lldz_pkg::lldz_sense_t sense_in,
    // Gate commands and soft start pull-down
    output logic high_gate_out,
    output logic low_gate_out,
    output logic soft_start_pin_out
);
    import lldz_pkg::*;

    // ------------------------------------------------------------
    // Limits at counter width
    // ------------------------------------------------------------
    localparam logic [15:0] NORM_MAX_L = 16'(NORM_MAX_DT_CYC);
    localparam logic [15:0] CAP_MAX_L = 16'(CAP_MAX_CYC);
    localparam logic [15:0] BLANK_L = 16'(BLANK_CYC);
    localparam logic [27:0] WAIT_L = 28'(WAIT_CYC - 1);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [1:0] ctrl_reg, ctrl_next;            // Run enable, overvoltage variant
    logic [15:0] on_prog_reg, on_prog_next;     // Programmed on time
    logic [15:0] rdata_reg, rdata_next;         // Read data, one cycle later
    lldz_state_t state_reg, state_next;         // Switching state
    logic [15:0] cnt_reg, cnt_next;             // On time or dead time count
    logic [15:0] dead_reg, dead_next;           // Measured dead time
    logic [15:0] on_time_reg, on_time_next;     // Working on time
    logic cap_reg, cap_next;                    // capacitive_region_flag
    logic ramp_reg, ramp_next;                  // Recovery ramp active
    logic slew_seen_reg, slew_seen_next;        // Slew rate went above threshold
    logic dir_prev_reg, dir_prev_next;          // Polarity last cycle
    logic peak_seen_reg, peak_seen_next;        // Peak trip in positive half
    logic [3:0] start_reg, start_next;          // Cycles since startup
    logic [27:0] wait_reg, wait_next;           // Fault restart wait
    lldz_cause_t cause_reg, cause_next;         // Last fault cause
    logic hg_reg, hg_next;                      // High gate flop
    logic lg_reg, lg_next;                      // Low gate flop
    logic ss_reg, ss_next;                      // Soft start pull flop
    logic cycle_end;                            // Full switching cycle completed
    logic fault_clear;                          // Clear persistence counters
    logic peak_trip, avg_hi_trip, avg_lo_trip, wind_trip;
    logic slew_done, dir_flip, fault_now;
    logic [15:0] dead_limit;
    lldz_cause_t cause_now;

    // ------------------------------------------------------------
    // Fault persistence
    // ------------------------------------------------------------
    assign fault_clear = (state_reg == LLDZ_FAULT) || (state_reg == LLDZ_IDLE);
    assign cycle_end = (state_reg == LLDZ_DEAD_LH) && (state_next == LLDZ_HIGH_ON);

    // Peak comparator counted per cycle, after the startup ignore window
    lldz_persist #(.CNT_W(3), .LIMIT(PEAK_CYCLES)) u_peak (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(fault_clear),
        .step_in(cycle_end),
        .cond_in(peak_seen_reg && (start_reg == START_IGNORE)),
        .trip_out(peak_trip)
    );

    // Average current, counted every clock while asserted
    lldz_persist #(.CNT_W(20), .LIMIT(AVG_HI_LIMIT)) u_avg_hi (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(fault_clear),
        .step_in(1'b1),
        .cond_in(sense_in.avg_current_high),
        .trip_out(avg_hi_trip)
    );

    lldz_persist #(.CNT_W(24), .LIMIT(AVG_LO_LIMIT)) u_avg_lo (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(fault_clear),
        .step_in(1'b1),
        .cond_in(sense_in.avg_current_low),
        .trip_out(avg_lo_trip)
    );

    // Winding overvoltage sampled at each cycle end
    lldz_persist #(.CNT_W(3), .LIMIT(WIND_CYCLES)) u_wind (
        .clock_in(clock_in),
        .sys_rst_in(sys_rst_in),
        .clear_in(fault_clear),
        .step_in(cycle_end),
        .cond_in(sense_in.winding_over),
        .trip_out(wind_trip)
    );

    // ------------------------------------------------------------
    // Fault and dead time terms
    // ------------------------------------------------------------
    always_comb begin
        cause_now.peak_overcurrent_fault = peak_trip;
        cause_now.avg_overcurrent_high_fault = avg_hi_trip;
        cause_now.avg_overcurrent_low_fault = avg_lo_trip;
        cause_now.winding_overvoltage_fault = wind_trip;
        cause_now.input_undervoltage_fault = sense_in.bulk_below_stop;
        cause_now.input_overvoltage_fault = ctrl_reg[CTRL_OVP_BIT] && sense_in.bulk_over;
        cause_now.gate_supply = sense_in.gate_supply_uv;
    end
    assign fault_now = |cause_now;
    // Slew done only after the rate was seen above threshold
    assign slew_done = slew_seen_reg && !sense_in.slew_high;
    // Polarity edges inside the blanking window are not seen
    assign dir_flip = (sense_in.current_direction_flag != dir_prev_reg) && (cnt_reg >= BLANK_L);
    assign dead_limit = cap_reg ? CAP_MAX_L : NORM_MAX_L;

    // ------------------------------------------------------------
    // Switching state, next values
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg + 1'b1;
        dead_next = dead_reg;
        on_time_next = on_time_reg;
        cap_next = cap_reg;
        ramp_next = ramp_reg;
        slew_seen_next = slew_seen_reg;
        dir_prev_next = sense_in.current_direction_flag;
        peak_seen_next = peak_seen_reg;
        start_next = start_reg;
        wait_next = wait_reg;
        cause_next = cause_reg;
        case (state_reg)
            LLDZ_IDLE: begin
                // Startup waits for enable and no pending fault
                cnt_next = '0;
                if (ctrl_reg[CTRL_RUN_BIT] && !fault_now) begin
                    state_next = LLDZ_HIGH_ON;
                    start_next = '0;
                    peak_seen_next = 1'b0;
                end
            end
            LLDZ_HIGH_ON: begin
                // Peak sampled only in the positive half cycle
                if (sense_in.peak_current_high) begin
                    peak_seen_next = 1'b1;
                end
                if (cnt_reg >= on_time_reg) begin
                    state_next = LLDZ_DEAD_HL;
                    cnt_next = '0;
                    slew_seen_next = 1'b0;
                    // Negative current at high turn-off is capacitive
                    cap_next = !sense_in.light_load && !sense_in.current_direction_flag;
                end
            end
            LLDZ_DEAD_HL: begin
                if (sense_in.slew_high) begin
                    slew_seen_next = 1'b1;
                end
                if ((cap_reg && dir_flip) || slew_done || cnt_reg >= dead_limit) begin
                    state_next = LLDZ_LOW_ON;
                    cnt_next = '0;
                    // Capacitive cycles keep the last good measurement
                    if (!cap_reg) begin
                        dead_next = cnt_reg;
                    end
                end
            end
            LLDZ_LOW_ON: begin
                if (cnt_reg >= on_time_reg) begin
                    state_next = LLDZ_DEAD_LH;
                    cnt_next = '0;
                    slew_seen_next = 1'b0;
                    // Positive current at low turn-off is capacitive
                    cap_next = !sense_in.light_load && sense_in.current_direction_flag;
                end
            end
            LLDZ_DEAD_LH: begin
                if (sense_in.slew_high) begin
                    slew_seen_next = 1'b1;
                end
                if (cap_reg ? (dir_flip || slew_done || cnt_reg >= dead_limit)
                            : (cnt_reg >= dead_reg)) begin
                    state_next = LLDZ_HIGH_ON;
                    cnt_next = '0;
                    peak_seen_next = 1'b0;
                    if (start_reg != START_IGNORE) begin
                        start_next = start_reg + 1'b1;
                    end
                    // Recovery ramps on time back up, one step a cycle
                    if (ramp_reg) begin
                        if (on_time_reg + RAMP_STEP >= on_prog_reg) begin
                            on_time_next = on_prog_reg;
                            ramp_next = 1'b0;
                        end else begin
                            on_time_next = on_time_reg + RAMP_STEP;
                        end
                    end
                end
            end
            LLDZ_FAULT: begin
                // Gates held off; overvoltage must clear before restart
                cnt_next = '0;
                if (wait_reg != WAIT_L) begin
                    wait_next = wait_reg + 1'b1;
                end else if (!(ctrl_reg[CTRL_OVP_BIT] && sense_in.bulk_over)) begin
                    state_next = LLDZ_IDLE;
                    cap_next = 1'b0;
                    ramp_next = 1'b0;
                    on_time_next = on_prog_reg;
                end
            end
            default: begin
                state_next = LLDZ_IDLE;
            end
        endcase
        // Capacitive detection forces a high-frequency restart ramp
        if (cap_next && !cap_reg) begin
            ramp_next = 1'b1;
            on_time_next = ON_TIME_MIN;
        end
        // Without a ramp the working on time follows software
        if (!ramp_next && state_reg != LLDZ_DEAD_LH) begin
            on_time_next = on_prog_reg;
        end
        // Any fault overrides the switching sequence
        if (fault_now && state_reg != LLDZ_FAULT && state_reg != LLDZ_IDLE) begin
            state_next = LLDZ_FAULT;
            wait_next = '0;
            cause_next = cause_now;
        end
        // Gate flops; fault and supply loss win immediately
        hg_next = (state_next == LLDZ_HIGH_ON) && !sense_in.bootstrap_uv;
        lg_next = (state_next == LLDZ_LOW_ON);
        if (sense_in.gate_supply_uv) begin
            hg_next = 1'b0;
            lg_next = 1'b0;
        end
        ss_next = ramp_next && (state_next != LLDZ_FAULT);
    end

    // Switching state registers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_reg <= LLDZ_IDLE;
            cnt_reg <= '0;
            dead_reg <= NORM_MAX_L;
            on_time_reg <= ON_TIME_RST;
            cap_reg <= 1'b0;
            ramp_reg <= 1'b0;
            slew_seen_reg <= 1'b0;
            dir_prev_reg <= 1'b0;
            peak_seen_reg <= 1'b0;
            start_reg <= '0;
            wait_reg <= '0;
            cause_reg <= '0;
            hg_reg <= 1'b0;
            lg_reg <= 1'b0;
            ss_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            dead_reg <= dead_next;
            on_time_reg <= on_time_next;
            cap_reg <= cap_next;
            ramp_reg <= ramp_next;
            slew_seen_reg <= slew_seen_next;
            dir_prev_reg <= dir_prev_next;
            peak_seen_reg <= peak_seen_next;
            start_reg <= start_next;
            wait_reg <= wait_next;
            cause_reg <= cause_next;
            hg_reg <= hg_next;
            lg_reg <= lg_next;
            ss_reg <= ss_next;
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        on_prog_next = on_prog_reg;
        rdata_next = '0;
        if (reg_wr_in) begin
            case (reg_addr_in)
                CTRL_OFS: ctrl_next = reg_wdata_in[1:0];
                // Zero on time would stall nothing but is meaningless; floor it
                ON_TIME_OFS: on_prog_next = (reg_wdata_in < ON_TIME_MIN) ? ON_TIME_MIN
                                                                         : reg_wdata_in;
                default: ctrl_next = ctrl_reg;
            endcase
        end
        if (reg_rd_in) begin
            case (reg_addr_in)
                CTRL_OFS: rdata_next = {14'h0000, ctrl_reg};
                ON_TIME_OFS: rdata_next = on_prog_reg;
                STATUS_OFS: rdata_next = {1'b0, cause_reg, ss_reg, cap_reg, state_reg};
                DEAD_OFS: rdata_next = dead_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    // Register port flops
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctrl_reg <= CTRL_RST;
            on_prog_reg <= ON_TIME_RST;
            rdata_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            on_prog_reg <= on_prog_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata_out = rdata_reg;
    assign high_gate_out = hg_reg;
    assign low_gate_out = lg_reg;
    assign soft_start_pin_out = ss_reg;
endmodule // lldz_core
`default_nettype wire

// [hdl/lldz_persist.sv]
`default_nettype none
// Counts consecutive steps with a condition true and trips at a limit
module lldz_persist #(
    parameter int CNT_W = 8,
    parameter int LIMIT = 4
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic clear_in,
    input wire logic step_in,
    input wire logic cond_in,
    // Result
    output logic trip_out
);
    import lldz_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1); // Count at which it trips

    logic [CNT_W-1:0] cnt_reg, cnt_next; // Consecutive true steps
    logic trip_reg, trip_next;           // Sticky until cleared

    // ------------------------------------------------------------
    // Next count
    // ------------------------------------------------------------
    always_comb begin
        cnt_next = cnt_reg;
        trip_next = trip_reg;
        if (clear_in) begin
            // Leftover counts never carry into a new start
            cnt_next = '0;
            trip_next = 1'b0;
        end else if (step_in) begin
            if (cond_in) begin
                // Saturate so a held condition cannot wrap
                if (cnt_reg != LAST) begin
                    cnt_next = cnt_reg + 1'b1;
                end
                if (cnt_reg == LAST) begin
                    trip_next = 1'b1;
                end
            end else begin
                // Any break restarts the run
                cnt_next = '0;
            end
        end
    end

    // Registers
    always_ff @(posedge clock_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cnt_reg <= '0;
            trip_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            trip_reg <= trip_next;
        end
    end

    assign trip_out = trip_reg;
endmodule // lldz_persist
`default_nettype wire

// [hdl/lldz_pkg.sv]
`default_nettype none
package lldz_pkg;
    // ------------------------------------------------------------
    // Timing base
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;                // Clock rate in MHz
    localparam int BLANK_NS = 400;               // Polarity blanking, least time
    localparam int BLANK_CYC = (BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int NORM_MAX_DT_NS = 1000;        // Normal dead time ceiling, longest
    localparam int NORM_MAX_DT_CYC = (NORM_MAX_DT_NS * CLK_MHZ) / 1000;
    localparam int CAP_MAX_DT_US = 150;          // Capacitive dead time ceiling
    localparam int CAP_MAX_DT_CYC = CAP_MAX_DT_US * CLK_MHZ;
    localparam int AVG_HI_MS = 2;                // High average current persistence
    localparam int AVG_HI_CYC = AVG_HI_MS * CLK_MHZ * 1000;
    localparam int AVG_LO_MS = 50;               // Low average current persistence
    localparam int AVG_LO_CYC = AVG_LO_MS * CLK_MHZ * 1000;
    localparam int FAULT_WAIT_S = 1;             // Restart wait after a fault
    localparam int FAULT_WAIT_CYC = FAULT_WAIT_S * CLK_MHZ * 1000000;
    // ------------------------------------------------------------
    // Switching cycle counts
    // ------------------------------------------------------------
    localparam int PEAK_CYCLES = 4;              // Consecutive peak trips
    localparam int WIND_CYCLES = 5;              // Consecutive winding overvoltage
    localparam logic [3:0] START_IGNORE = 4'hF;  // Startup cycles with peak ignored
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] CTRL_OFS = 4'h0;      // Run enable, overvoltage variant
    localparam logic [3:0] ON_TIME_OFS = 4'h4;   // Half-period on time in cycles
    localparam logic [3:0] STATUS_OFS = 4'h8;    // State, flags, fault cause
    localparam logic [3:0] DEAD_OFS = 4'hC;      // Measured dead time
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_OVP_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [15:0] ON_TIME_RST = 16'h0190;
    localparam logic [15:0] ON_TIME_MIN = 16'h0020; // Recovery start on time
    localparam logic [15:0] RAMP_STEP = 16'h0004;   // Recovery on time step per cycle
    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        LLDZ_IDLE    = 6'h01,
        LLDZ_HIGH_ON = 6'h02,
        LLDZ_DEAD_HL = 6'h04,
        LLDZ_LOW_ON  = 6'h08,
        LLDZ_DEAD_LH = 6'h10,
        LLDZ_FAULT   = 6'h20
    } lldz_state_t;

    // Comparator inputs from analog sensing
    typedef struct packed {
        logic current_direction_flag;  // High when resonant current is positive
        logic peak_current_high;       // Above peak_current_threshold
        logic avg_current_high;        // High average threshold comparator
        logic avg_current_low;         // Low average threshold comparator
        logic winding_over;            // bias_winding_sense overvoltage comparator
        logic bulk_below_stop;         // bulk_voltage_sense under bulk_stop_level
        logic bulk_over;               // Above bulk_overvoltage_rise_level
        logic bootstrap_uv;            // bootstrap_supply undervoltage
        logic gate_supply_uv;          // regulated_gate_supply undervoltage
        logic slew_high;               // switch_node slew rate above threshold
        logic light_load;              // Burst control reports light load
    } lldz_sense_t;

    // Latched fault cause
    typedef struct packed {
        logic gate_supply;
        logic input_overvoltage_fault;
        logic input_undervoltage_fault;
        logic winding_overvoltage_fault;
        logic avg_overcurrent_low_fault;
        logic avg_overcurrent_high_fault;
        logic peak_overcurrent_fault;
    } lldz_cause_t;
endpackage
`default_nettype wire

// [testbench/lldz_bridge_model.sv]
`default_nettype none
// Half-bridge and current comparator stand-in
module lldz_bridge_model (
    // Clock and gate commands
    input wire logic clock_in,
    input wire logic high_gate_in,
    input wire logic low_gate_in,
    // Scenario controls
    input wire logic slew_en_in,
    input wire logic cap_in,
    // Comparator levels
    output logic slew_high_out,
    output logic dir_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] since_reg = 8'h00; // Cycles since both gates fell
    logic last_high_reg = 1'b0; // Last side that conducted
    always @(posedge clock_in) begin
        if (high_gate_in || low_gate_in) since_reg <= 8'h00;
        else if (since_reg != 8'hFF) since_reg <= since_reg + 8'h01;
        if (high_gate_in) last_high_reg <= 1'b1;
        if (low_gate_in) last_high_reg <= 1'b0;
    end
    // Saturating count: a long idle gives no stray slew
    assign slew_high_out = slew_en_in && since_reg >= 8'h03 && since_reg <= 8'h06;
    // Capacitive operation reverses the current
    assign dir_out = last_high_reg ^ cap_in;
endmodule // lldz_bridge_model
`default_nettype wire

// [testbench/lldz_core_assertions.sv]
`default_nettype none
module lldz_core_assertions (
    // Watched ports
    input wire logic clock_in,
    input wire logic sys_rst_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire lldz_pkg::lldz_sense_t sense_in,
    input wire logic high_gate_out,
    input wire logic low_gate_out,
    input wire logic soft_start_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import lldz_pkg::*;
    default clocking @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire logic off_w = !high_gate_out && !low_gate_out; // Both gates off
    sequence off_hold_s;
        off_w [*8];
    endsequence
    overlap_free_a: assert property (!(high_gate_out && low_gate_out))
        else $error("gates overlap");
    break_make_a: assert property ($changed(high_gate_out) |-> !$changed(low_gate_out))
        else $error("turn-on without dead time");
    supply_uv_a: assert property (sense_in.gate_supply_uv |=> off_hold_s)
        else $error("gates on after supply undervoltage");
    boot_uv_a: assert property (sense_in.bootstrap_uv |=> !high_gate_out)
        else $error("high gate on with bootstrap low");
    bulk_stop_a: assert property (sense_in.bulk_below_stop && !off_w |-> ##2 off_hold_s)
        else $error("switching after bulk stop");
    dead_bound_a: assert property ($fell(high_gate_out) && !sense_in.bulk_over |->
        ##[1:320] !off_w)
        else $error("dead time too long");
    ss_in_dead_a: assert property ($rose(soft_start_pin_out) |-> off_w)
        else $error("soft start pull outside dead time");
    light_quiet_a: assert property (sense_in.light_load [*3] |-> !$rose(soft_start_pin_out))
        else $error("capacitive recovery at light load");
    rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside read slot");
endmodule // lldz_core_assertions
bind lldz_core lldz_core_assertions lldz_core_assertions_i (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .sense_in(sense_in), .high_gate_out(high_gate_out), .low_gate_out(low_gate_out),
    .soft_start_pin_out(soft_start_pin_out));
`default_nettype wire

// [testbench/lldz_core_tb.sv]
`default_nettype none
module lldz_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lldz_pkg::*;
    logic clock_in = 1'b0, sys_rst_in = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
    logic slew_en = 1'b0, cap = 1'b0, hi, lo, ss, slew, dir;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000, rdata, w, q[$]; // q: expected read data
    logic [10:0] sense = 11'h000; // Comparator levels the bench owns
    int failures = 0, n_tests = 0, n, k;
    always #2.5 clock_in = ~clock_in;
    // Short counts keep the run brief
    lldz_core #(.CAP_MAX_CYC(300), .AVG_HI_LIMIT(40), .AVG_LO_LIMIT(80), .WAIT_CYC(200))
    lldz_core_i (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .sense_in({dir, sense[9:2], slew, sense[0]}), .high_gate_out(hi),
        .low_gate_out(lo), .soft_start_pin_out(ss));
    lldz_bridge_model lldz_bridge_model_i (.clock_in(clock_in), .high_gate_in(hi),
        .low_gate_in(lo), .slew_en_in(slew_en), .cap_in(cap), .slew_high_out(slew),
        .dir_out(dir));
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One bus cycle; a read notes its expected data
    task automatic bus(input logic w_en, input logic [3:0] a, input logic [15:0] d);
        @(posedge clock_in);
        addr <= a;
        wdata <= d;
        wr <= w_en;
        rd <= !w_en;
        if (!w_en) q.push_back(d);
        @(posedge clock_in);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    always @(posedge clock_in) begin
        rd_d <= rd;
        if (rd_d) chk("rdata", q.pop_front(), rdata);
    end
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h5C2714D7));
        repeat (4) @(posedge clock_in);
        sys_rst_in <= 1'b0;
        bus(0, ON_TIME_OFS, ON_TIME_RST);
        bus(0, 4'h2, 16'h0000);
        bus(1, ON_TIME_OFS, 16'h0005);
        bus(0, ON_TIME_OFS, ON_TIME_MIN);
        w = ON_TIME_MIN + 16'($urandom_range(63));
        bus(1, ON_TIME_OFS, w);
        bus(0, ON_TIME_OFS, w);
        bus(0, STATUS_OFS, 16'h0001);
        bus(1, CTRL_OFS, 16'h0003);
        // No slew seen: ceiling taken and kept
        repeat (1000) @(posedge clock_in);
        bus(0, DEAD_OFS, 16'h00C8);
        slew_en <= 1'b1;
        sense[3] <= 1'b1;
        repeat (300) @(posedge clock_in);
        sense[3] <= 1'b0;
        repeat (300) @(posedge clock_in);
        $display("register and dead time tests done");
        // Each fault held until the gates stay off, cause read during the wait
        for (int i = 9; i > 1; i--) if (i != 3) begin
            sense[i] <= 1'b1;
            k = 0;
            for (n = 0; k < 40 && n < 9000; n++) begin
                @(posedge clock_in);
                k = (hi || lo) ? 0 : k + 1;
            end
            if (i == 4) repeat (300) @(posedge clock_in);
            bus(0, STATUS_OFS, 16'h0020 | (16'h0001 << ((i == 2) ? 14 : 17 - i)));
            sense[i] <= 1'b0;
            repeat (300) @(posedge clock_in);
            $display("fault test %0d done", i);
        end
        cap <= 1'b1;
        for (n = 0; n < 9000 && ss !== 1'b1; n++) @(posedge clock_in);
        chk("soft start", 16'h0001, {15'h0000, ss});
        cap <= 1'b0;
        for (n = 0; n < 20000 && ss !== 1'b0; n++) @(posedge clock_in);
        chk("ramp end", 16'h0000, {15'h0000, ss});
        sense[0] <= 1'b1;
        repeat (4) @(posedge clock_in);
        cap <= 1'b1;
        repeat (2000) @(posedge clock_in);
        chk("light load", 16'h0000, {15'h0000, ss});
        $display("capacitive tests done");
        end_of_test();
    end
    // Hang guard, well past the expected run
    initial begin
        #450us;
        failures++;
        end_of_test();
    end
endmodule // lldz_core_tb
`default_nettype wire
